// >>> hdl/fbfw_top.sv
// Purpose: byte buffer with fill threshold, behind the host register port
// Assumes: reg strobes come from host interface logic on core_clk
// Notes: register read data valid one edge after reg_rd
//
// How it works
// - control bit 7 picks 255 or 512 bytes
// - near_full when depth minus count <= threshold
// - near_empty when count <= threshold
// - clear bit empties buffer, reads as zero
// - control bit 2 is threshold bit 8, ignored in small mode
// - control bits 1:0 show count bits 9:8
// - threshold register holds threshold bits 7:0
// - port write increments, port read decrements count
// - count register shows count bits, reset zero
// - pointer holds at port, else increments
// - flag risings latch into sticky event bits
`timescale 1ns/10ps
`include "fbfw_map.svh"
module fbfw_top
  import fbfw_pkg::*;
#(
  parameter int DEPTH_MAX = 512
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // address pointer load from host interface
  input wire logic ptr_load,
  input wire fbfw_addr_t ptr_value,
  output fbfw_addr_t addr_ptr,
  // register access at addr_ptr
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire fbfw_byte_t reg_wdata,
  output fbfw_byte_t reg_rdata,
  output logic reg_rvalid,
  // status
  output fbfw_count_t fill_count,
  output logic near_full_flag,
  output logic near_empty_flag,
  // sticky events and their clears
  input wire logic near_full_event_clr,
  input wire logic near_empty_event_clr,
  output logic near_full_event,
  output logic near_empty_event
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  fbfw_mem_if mem ();
  logic depth_select;
  logic threshold_msb;
  fbfw_byte_t threshold_low_bits;
  fbfw_count_t count;
  fbfw_index_t wr_ptr;
  fbfw_index_t rd_ptr;
  logic nf_q;
  logic ne_q;
  logic nf_evt;
  logic ne_evt;
  fbfw_byte_t rdata_q;
  logic rvalid_q;
  logic rsel_mem_q;

  logic next_depth_select;
  logic next_threshold_msb;
  fbfw_byte_t next_threshold_low_bits;
  fbfw_count_t next_count;
  fbfw_index_t next_wr_ptr;
  fbfw_index_t next_rd_ptr;
  fbfw_addr_t next_addr_ptr;
  logic next_nf_evt;
  logic next_ne_evt;
  fbfw_byte_t next_rdata;
  logic next_rsel_mem;

  fbfw_count_t depth;
  fbfw_count_t threshold;
  logic nf_live;
  logic ne_live;
  logic do_push;
  logic do_pop;
  logic do_clear;
  fbfw_byte_t ctrl_view;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_reg(input fbfw_addr_t a, input fbfw_addr_t o);
    return a == o;
  endfunction

  function automatic fbfw_index_t wrap_inc(input fbfw_index_t p,
                                           input fbfw_count_t d);
    if ({1'b0, p} == d - 10'h001) begin
      return 9'h000;
    end else begin
      return p + 9'h001;
    end
  endfunction

  // ----------------------------------------
  // derived levels
  // ----------------------------------------
  // 255 bytes when set, 512 when clear
  assign depth = depth_select ? `FBFW_DEPTH_SMALL
                              : `FBFW_DEPTH_LARGE;
  // msb ignored in small mode
  assign threshold = {1'b0, threshold_msb & ~depth_select,
                      threshold_low_bits};
  assign nf_live = (depth - count) <= threshold;
  assign ne_live = count <= threshold;
  assign do_clear = reg_wr & is_reg(addr_ptr, `FBFW_OFS_CONTROL)
                    & reg_wdata[`FBFW_BIT_CLEAR];
  assign do_push = reg_wr & is_reg(addr_ptr, `FBFW_OFS_PORT)
                   & (count < depth);
  assign do_pop = reg_rd & is_reg(addr_ptr, `FBFW_OFS_PORT)
                  & (count != 10'h000);
  assign ctrl_view = {depth_select, nf_live, ne_live, 1'b0, 1'b0,
                      threshold_msb, count[9:8]};

  // ----------------------------------------
  // storage
  // ----------------------------------------
  assign mem.wr_en = do_push;
  assign mem.wr_addr = wr_ptr;
  assign mem.wr_data = reg_wdata;
  assign mem.rd_addr = rd_ptr;

  fbfw_mem #(
    .DEPTH(DEPTH_MAX)
  ) fbfw_mem_inst (
    .core_clk(core_clk),
    .mem(mem.store)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_depth_select = depth_select;
    next_threshold_msb = threshold_msb;
    next_threshold_low_bits = threshold_low_bits;
    next_count = count;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_addr_ptr = addr_ptr;
    next_rdata = 8'h00;
    next_rsel_mem = 1'b0;
    // set wins over clear
    next_nf_evt = (nf_evt & ~near_full_event_clr)
                  | (nf_live & ~nf_q);
    next_ne_evt = (ne_evt & ~near_empty_event_clr)
                  | (ne_live & ~ne_q);

    if (reg_wr) begin
      if (is_reg(addr_ptr, `FBFW_OFS_CONTROL)) begin
        next_depth_select = reg_wdata[`FBFW_BIT_DEPTH_SEL];
        next_threshold_msb = reg_wdata[`FBFW_BIT_THR_MSB];
      end else if (is_reg(addr_ptr, `FBFW_OFS_THRESH)) begin
        next_threshold_low_bits = reg_wdata;
      end
    end

    if (reg_rd) begin
      if (is_reg(addr_ptr, `FBFW_OFS_CONTROL)) begin
        next_rdata = ctrl_view;
      end else if (is_reg(addr_ptr, `FBFW_OFS_THRESH)) begin
        next_rdata = threshold_low_bits;
      end else if (is_reg(addr_ptr, `FBFW_OFS_COUNT)) begin
        next_rdata = count[7:0];
      end else if (is_reg(addr_ptr, `FBFW_OFS_PORT)) begin
        next_rsel_mem = do_pop;
      end
    end

    // fifo order pointers
    if (do_push) begin
      next_wr_ptr = wrap_inc(wr_ptr, depth);
    end
    if (do_pop) begin
      next_rd_ptr = wrap_inc(rd_ptr, depth);
    end
    if (do_push & ~do_pop) begin
      next_count = count + 10'h001;
    end else if (do_pop & ~do_push) begin
      next_count = count - 10'h001;
    end
    if (do_clear) begin
      next_count = `FBFW_RST_COUNT;
      next_wr_ptr = 9'h000;
      next_rd_ptr = 9'h000;
    end

    if (ptr_load) begin
      next_addr_ptr = ptr_value;
    end else if ((reg_wr | reg_rd)
                 & ~is_reg(addr_ptr, `FBFW_OFS_PORT)) begin
      next_addr_ptr = addr_ptr + 7'h01;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      depth_select <= `FBFW_RST_DEPTH_SEL;
      threshold_msb <= 1'b0;
      threshold_low_bits <= 8'h00;
      count <= `FBFW_RST_COUNT;
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      addr_ptr <= `FBFW_RST_PTR;
      nf_q <= 1'b0;
      ne_q <= 1'b0;
      nf_evt <= 1'b0;
      ne_evt <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      rsel_mem_q <= 1'b0;
    end else begin
      depth_select <= next_depth_select;
      threshold_msb <= next_threshold_msb;
      threshold_low_bits <= next_threshold_low_bits;
      count <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      addr_ptr <= next_addr_ptr;
      nf_q <= nf_live;
      ne_q <= ne_live;
      nf_evt <= next_nf_evt;
      ne_evt <= next_ne_evt;
      rdata_q <= next_rdata;
      rvalid_q <= reg_rd;
      rsel_mem_q <= next_rsel_mem;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rsel_mem_q ? mem.rd_data : rdata_q;
  assign reg_rvalid = rvalid_q;
  assign fill_count = count;
  assign near_full_flag = nf_q;
  assign near_empty_flag = ne_q;
  assign near_full_event = nf_evt;
  assign near_empty_event = ne_evt;
endmodule

// >>> shared/fbfw_map.svh
// Purpose: offsets, field positions and reset values of the byte buffer
// Assumes: 7-bit host register address, 8-bit register data
// Notes: definitions only
`ifndef FBFW_MAP_SVH
`define FBFW_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FBFW_OFS_CONTROL 7'h02
`define FBFW_OFS_THRESH 7'h03
`define FBFW_OFS_COUNT 7'h04
`define FBFW_OFS_PORT 7'h05

// ----------------------------------------
// buffer_control fields
// ----------------------------------------
`define FBFW_BIT_DEPTH_SEL 7
`define FBFW_BIT_NEAR_FULL 6
`define FBFW_BIT_NEAR_EMPTY 5
`define FBFW_BIT_CLEAR 4
`define FBFW_BIT_THR_MSB 2
`define FBFW_BIT_CNT_HI 0

// ----------------------------------------
// depths and reset values
// ----------------------------------------
`define FBFW_DEPTH_SMALL 10'h0ff
`define FBFW_DEPTH_LARGE 10'h200
`define FBFW_RST_DEPTH_SEL 1'b0
`define FBFW_RST_THRESH 9'h000
`define FBFW_RST_COUNT 10'h000
`define FBFW_RST_PTR 7'h00

`endif

// >>> shared/fbfw_pkg.sv
// Purpose: types shared by the byte buffer modules
// Assumes: nothing
// Notes: numbers live in fbfw_map.svh
package fbfw_pkg;
  typedef logic [7:0] fbfw_byte_t;
  typedef logic [8:0] fbfw_index_t;
  typedef logic [9:0] fbfw_count_t;
  typedef logic [6:0] fbfw_addr_t;
endpackage

// >>> shared/fbfw_mem_if.sv
// Purpose: port bundle between buffer control and its storage
// Assumes: single clock
// Notes: read data registered inside the storage
`timescale 1ns/10ps
interface fbfw_mem_if;
  import fbfw_pkg::*;
  logic wr_en;
  fbfw_index_t wr_addr;
  fbfw_byte_t wr_data;
  fbfw_index_t rd_addr;
  fbfw_byte_t rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface

// >>> hdl/fbfw_mem.sv
// Purpose: byte storage of the buffer, registered read
// Assumes: one write port, one read port, same clock
// Notes: read data follows rd_addr one edge later
`timescale 1ns/10ps
module fbfw_mem
  import fbfw_pkg::*;
#(
  parameter int DEPTH = 512
) (
  // clock
  input wire logic core_clk,
  // storage port
  fbfw_mem_if.store mem
);
  fbfw_byte_t store_q [DEPTH];
  fbfw_byte_t rd_q;

  always_ff @(posedge core_clk) begin
    if (mem.wr_en) begin
      store_q[mem.wr_addr] <= mem.wr_data;
    end
    rd_q <= store_q[mem.rd_addr];
  end

  assign mem.rd_data = rd_q;
endmodule

// >>> bench/fbfw_props.sv
// Purpose: port-level checks of the byte buffer
// Assumes: single clock, rst async active high
// Notes: bound to fbfw_top below
`timescale 1ns/10ps
module fbfw_props
  import fbfw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host side
  input wire logic ptr_load,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire fbfw_byte_t reg_wdata,
  input wire fbfw_addr_t addr_ptr,
  input wire fbfw_byte_t reg_rdata,
  // status
  input wire fbfw_count_t fill_count,
  input wire logic near_empty_flag,
  input wire logic near_full_flag,
  input wire logic near_full_event_clr,
  input wire logic near_full_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic acc = reg_wr | reg_rd;
  AST_PTR_HOLD: assert property (!ptr_load && acc && addr_ptr == 7'h05
    |=> addr_ptr == 7'h05) else $error("pointer moved at port");
  AST_PTR_INC: assert property (!ptr_load && acc && addr_ptr != 7'h05
    |=> addr_ptr == $past(addr_ptr) + 7'h01) else $error("no increment");
  AST_CNT_INC: assert property (reg_wr && addr_ptr == 7'h05 &&
    fill_count < 10'h0ff |=> fill_count == $past(fill_count) + 10'h001)
    else $error("count not raised");
  AST_CNT_DEC: assert property (reg_rd && addr_ptr == 7'h05 &&
    fill_count != 10'h000 |=> fill_count == $past(fill_count) - 10'h001)
    else $error("count not lowered");
  AST_CLR: assert property (reg_wr && addr_ptr == 7'h02 && reg_wdata[4]
    |=> fill_count == 10'h000) else $error("clear missed");
  AST_CLR_RD: assert property (reg_rd && addr_ptr == 7'h02
    |=> !reg_rdata[4]) else $error("clear bit reads one");
  AST_NE: assert property (fill_count == 10'h000 |=> near_empty_flag)
    else $error("near empty missing");
  AST_NF: assert property (fill_count == 10'h200 |=> near_full_flag)
    else $error("near full missing");
  AST_EV_SET: assert property ($rose(near_full_flag) |-> ##[0:1]
    near_full_event) else $error("event not latched");
  AST_EV_HOLD: assert property (near_full_event && !near_full_event_clr
    |=> near_full_event) else $error("event dropped");
endmodule
bind fbfw_top fbfw_props fbfw_props_inst (.*);

// >>> bench/fbfw_host.sv
// Purpose: host controller model issuing register accesses
// Assumes: pointer loaded one cycle before each access
// Notes: drives on falling edge
`timescale 1ns/10ps
module fbfw_host
  import fbfw_pkg::*;
(
  // clock and read data
  input wire logic core_clk,
  input wire fbfw_byte_t reg_rdata,
  // requests
  output logic ptr_load,
  output fbfw_addr_t ptr_value,
  output logic reg_wr,
  output logic reg_rd,
  output fbfw_byte_t reg_wdata
);
  initial begin
    ptr_load = 1'b0;
    ptr_value = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one access; read data taken while the answer stands
  task automatic acc(input fbfw_addr_t a, input logic w,
    input fbfw_byte_t d, output fbfw_byte_t q);
    @(negedge core_clk);
    ptr_load = 1'b1;
    ptr_value = a;
    @(negedge core_clk);
    ptr_load = 1'b0;
    reg_wr = w;
    reg_rd = !w;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask
endmodule

// >>> bench/frontend_byte_fifo_with_watermark_test.sv
// Purpose: self-checking bench of the byte buffer
// Assumes: host model fbfw_host drives the register port
// Notes: event clears pulsed once, reset repeated in mid-run
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module frontend_byte_fifo_with_watermark_test;
  import fbfw_pkg::*;
  logic core_clk, rst, ptr_load, reg_wr, reg_rd, reg_rvalid;
  logic nf_flag, ne_flag, nf_ev, ne_ev;
  logic nf_clr = 1'b0;
  logic ne_clr = 1'b0;
  fbfw_addr_t ptr_value, addr_ptr;
  fbfw_byte_t reg_wdata, reg_rdata, q;
  fbfw_count_t fill_count;
  int n_fail = 0, compares = 0, cycles = 0;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  fbfw_top fbfw_top_inst (.core_clk(core_clk), .rst(rst),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .addr_ptr(addr_ptr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .fill_count(fill_count), .near_full_flag(nf_flag),
    .near_empty_flag(ne_flag), .near_full_event_clr(nf_clr),
    .near_empty_event_clr(ne_clr), .near_full_event(nf_ev),
    .near_empty_event(ne_ev));
  fbfw_host fbfw_host_inst (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  task automatic final_report();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic wr(input fbfw_addr_t a, input fbfw_byte_t d);
    fbfw_host_inst.acc(a, 1'b1, d, q);
  endtask
  task automatic rd(input fbfw_addr_t a);
    fbfw_host_inst.acc(a, 1'b0, 8'h00, q);
    `CHK(reg_rvalid, 1'b1)
  endtask
  task automatic t_reset();
    rd(7'h04);
    `CHK(q, 8'h00)
    rd(7'h02);
    `CHK(q, 8'h20)
    $display("test reset done");
  endtask
  task automatic t_order();
    for (int i = 0; i < 3; i++) wr(7'h05, 8'ha0 + i);
    `CHK(addr_ptr, 7'h05)
    `CHK(fill_count, 10'h003)
    rd(7'h04);
    `CHK(q, 8'h03)
    for (int i = 0; i < 3; i++) begin
      rd(7'h05);
      `CHK(q, 8'ha0 + i)
    end
    rd(7'h04);
    `CHK(q, 8'h00)
    $display("test order done");
  endtask
  task automatic t_levels();
    wr(7'h03, 8'h02);
    repeat (3) wr(7'h05, 8'h11);
    rd(7'h02);
    `CHK(q, 8'h00)
    wr(7'h02, 8'h04);
    rd(7'h02);
    `CHK(q, 8'h24)
    // clear together with the depth change
    wr(7'h02, 8'h94);
    rd(7'h04);
    `CHK(q, 8'h00)
    repeat (253) wr(7'h05, 8'h22);
    rd(7'h02);
    `CHK(q, 8'hc4)
    `CHK(nf_flag, 1'b1)
    wr(7'h02, 8'h10);
    repeat (256) wr(7'h05, 8'h33);
    rd(7'h02);
    `CHK(q, 8'h01)
    `CHK(nf_ev, 1'b1)
    `CHK(ne_ev, 1'b1)
    $display("test levels done");
  endtask
  task automatic t_full();
    repeat (256) wr(7'h05, 8'h44);
    // one more byte is refused when full
    wr(7'h05, 8'h55);
    `CHK(fill_count, 10'h200)
    rd(7'h02);
    `CHK(q, 8'h42)
    `CHK(nf_flag, 1'b1)
    `CHK(ne_flag, 1'b0)
    rd(7'h05);
    `CHK(q, 8'h33)
    `CHK(fill_count, 10'h1ff)
    @(negedge core_clk);
    nf_clr = 1'b1;
    ne_clr = 1'b1;
    @(negedge core_clk);
    nf_clr = 1'b0;
    ne_clr = 1'b0;
    `CHK(nf_ev, 1'b0)
    `CHK(ne_ev, 1'b0)
    wr(7'h02, 8'h10);
    rd(7'h04);
    `CHK(q, 8'h00)
    `CHK(ne_ev, 1'b1)
    `CHK(nf_ev, 1'b0)
    repeat (3) wr(7'h05, 8'h66);
    rd(7'h04);
    `CHK(q, 8'h03)
    `CHK(ne_flag, 1'b0)
    `CHK(ne_ev, 1'b1)
    // reset again in mid-run
    @(negedge core_clk);
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    `CHK(fill_count, 10'h000)
    `CHK(addr_ptr, 7'h00)
    `CHK(nf_ev, 1'b0)
    rd(7'h05);
    `CHK(q, 8'h00)
    `CHK(fill_count, 10'h000)
    $display("test full done");
  endtask
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_order();
    t_levels();
    t_full();
    final_report();
  end
endmodule
